/* tspm_consts.svh */
// Register offsets, field positions, reset values and probe codes for the
// test signal probe mux. Assumes an 8-bit data, 4-bit address register port.
`ifndef TSPM_CONSTS_SVH
`define TSPM_CONSTS_SVH

`define TSPM_ADDR_W 4
`define TSPM_DATA_W 8

`define TSPM_ADDR_ANALOG_SEL 4'h0
`define TSPM_ADDR_DIGITAL_SEL 4'h1
`define TSPM_ADDR_MULTIFUNCTION_OUT_PIN_SRC 4'h2
`define TSPM_ADDR_STATUS 4'h3

`define TSPM_RST_ANALOG_SEL 5'h00
`define TSPM_RST_DIGITAL_CODE 7'h00
`define TSPM_RST_ROUTE 1'b0
`define TSPM_RST_MULTIFUNCTION_OUT_PIN_SRC 3'h0

`define TSPM_ROUTE_BIT 7
`define TSPM_ST_PIN_BIT 0
`define TSPM_ST_PROBE_BIT 1
`define TSPM_ST_ANA_RSV_BIT 2
`define TSPM_ST_DIG_UNDEF_BIT 3

`define TSPM_ANALOG_LAST_CODE 5'h0C

`define TSPM_DCODE_NONE 8'h00
`define TSPM_DCODE_RX_DATA 8'hF4
`define TSPM_DCODE_RX_VALID 8'hE4
`define TSPM_DCODE_RX_COLL 8'hD4
`define TSPM_DCODE_SER_CLK 8'hC4
`define TSPM_DCODE_RD_SYNC 8'hB5
`define TSPM_DCODE_WR_SYNC 8'hA5
`define TSPM_DCODE_CORE_CLK 8'h96

`define TSPM_SRC_LOW 3'h0
`define TSPM_SRC_HIGH 3'h1
`define TSPM_SRC_ENVELOPE 3'h2
`define TSPM_SRC_TX_NRZ 3'h3
`define TSPM_SRC_MANCH_SUBC 3'h4
`define TSPM_SRC_MANCH 3'h5

`endif

/* tspm_pkg.sv */
// Types shared by the test signal probe mux files.
// Assumes the constants header is included beside it.
package tspm_pkg;

  typedef enum logic [3:0] {
    TSPM_DP_NORMAL,
    TSPM_DP_RX_DATA,
    TSPM_DP_RX_VALID,
    TSPM_DP_RX_COLL,
    TSPM_DP_SER_CLK,
    TSPM_DP_RD_SYNC,
    TSPM_DP_WR_SYNC,
    TSPM_DP_CORE_CLK,
    TSPM_DP_UNDEFINED
  } tspm_dprobe_t;

  typedef struct packed {
    logic rx_data;
    logic rx_valid;
    logic rx_coll;
    logic serial_clk;
    logic rd_sync;
    logic wr_sync;
    logic core_clk;
  } tspm_probe_t;

  typedef struct packed {
    logic envelope;
    logic tx_nrz;
    logic manch_subc;
    logic manch;
  } tspm_normal_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tspm_bus_t;

endpackage : tspm_pkg

/* tspm_normal_src.sv */
// Normal source selector of the multifunction output pin.
// Purely combinational; the top registers the result.
`timescale 1ns/10ps
`default_nettype none
`include "tspm_consts.svh"

module tspm_normal_src
  import tspm_pkg::*;
(
  input wire logic [2:0] src_sel_in,
  input wire tspm_normal_t sigs_in,
  output logic level_out
);

  always_comb begin
    case (src_sel_in)
      `TSPM_SRC_LOW: level_out = 1'b0;
      `TSPM_SRC_HIGH: level_out = 1'b1;
      `TSPM_SRC_ENVELOPE: level_out = sigs_in.envelope;
      `TSPM_SRC_TX_NRZ: level_out = sigs_in.tx_nrz;
      `TSPM_SRC_MANCH_SUBC: level_out = sigs_in.manch_subc;
      `TSPM_SRC_MANCH: level_out = sigs_in.manch;
      // Reserved codes hold the pin low
      default: level_out = 1'b0;
    endcase
  end

endmodule : tspm_normal_src
`default_nettype wire

/* tspm_dprobe_dec.sv */
// Decoder of the digital probe selection into a probe kind and a level.
// Purely combinational; the top registers the result.
`timescale 1ns/10ps
`default_nettype none
`include "tspm_consts.svh"

module tspm_dprobe_dec
  import tspm_pkg::*;
(
  input wire logic route_in,
  input wire logic [6:0] code_in,
  input wire tspm_probe_t probes_in,
  input wire logic normal_level_in,
  output tspm_dprobe_t kind_out,
  output logic level_out
);

  function automatic tspm_dprobe_t decode(input logic route,
                                          input logic [6:0] code);
    tspm_dprobe_t k;
    k = TSPM_DP_UNDEFINED;
    if (!route || code == 7'(`TSPM_DCODE_NONE)) begin
      k = TSPM_DP_NORMAL;
    end else begin
      case ({route, code})
        `TSPM_DCODE_RX_DATA: k = TSPM_DP_RX_DATA;
        `TSPM_DCODE_RX_VALID: k = TSPM_DP_RX_VALID;
        `TSPM_DCODE_RX_COLL: k = TSPM_DP_RX_COLL;
        `TSPM_DCODE_SER_CLK: k = TSPM_DP_SER_CLK;
        `TSPM_DCODE_RD_SYNC: k = TSPM_DP_RD_SYNC;
        `TSPM_DCODE_WR_SYNC: k = TSPM_DP_WR_SYNC;
        `TSPM_DCODE_CORE_CLK: k = TSPM_DP_CORE_CLK;
        default: k = TSPM_DP_UNDEFINED;
      endcase
    end
    return k;
  endfunction : decode

  always_comb begin
    kind_out = decode(route_in, code_in);
    case (kind_out)
      TSPM_DP_NORMAL: level_out = normal_level_in;
      TSPM_DP_RX_DATA: level_out = probes_in.rx_data;
      TSPM_DP_RX_VALID: level_out = probes_in.rx_valid;
      TSPM_DP_RX_COLL: level_out = probes_in.rx_coll;
      TSPM_DP_SER_CLK: level_out = probes_in.serial_clk;
      TSPM_DP_RD_SYNC: level_out = probes_in.rd_sync;
      TSPM_DP_WR_SYNC: level_out = probes_in.wr_sync;
      TSPM_DP_CORE_CLK: level_out = probes_in.core_clk;
      // Production test codes drive the pin low
      default: level_out = 1'b0;
    endcase
  end

endmodule : tspm_dprobe_dec
`default_nettype wire

/* tspm_top.sv */
// Test signal probe mux: analog node select for the auxiliary analog pin
// and digital probe routing onto the multifunction output pin.
// Assumes all probe inputs are synchronous to SYS_CLK_IN and a register
// master that keeps strobes one cycle long and never both at once.
// Reserved analog and undefined digital codes are flagged in the status register, never refused.
`timescale 1ns/10ps
`default_nettype none
`include "tspm_consts.svh"

module tspm_top
  import tspm_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic RX_DATA_IN,
  input wire logic RX_VALID_IN,
  input wire logic RX_COLL_IN,
  input wire logic SERIAL_CLK_IN,
  input wire logic RD_SYNC_IN,
  input wire logic WR_SYNC_IN,
  input wire logic CORE_CLK_IN,
  input wire logic ENVELOPE_IN,
  input wire logic TX_NRZ_IN,
  input wire logic MANCH_SUBC_IN,
  input wire logic MANCH_IN,
  output logic MULTIFUNCTION_OUT_PIN_OUT,
  output logic [4:0] ANALOG_PROBE_CODE_OUT,
  output logic ANALOG_PROBE_VALID_OUT
);

  // Bus request bundle
  tspm_bus_t bus;
  assign bus.addr = REG_ADDR_IN;
  assign bus.wdata = REG_WDATA_IN;
  assign bus.wr = REG_WR_IN;
  assign bus.rd = REG_RD_IN;

  // Digital probe sources
  tspm_probe_t probes;
  assign probes.rx_data = RX_DATA_IN;
  assign probes.rx_valid = RX_VALID_IN;
  assign probes.rx_coll = RX_COLL_IN;
  assign probes.serial_clk = SERIAL_CLK_IN;
  assign probes.rd_sync = RD_SYNC_IN;
  assign probes.wr_sync = WR_SYNC_IN;
  assign probes.core_clk = CORE_CLK_IN;

  // Normal pin sources
  tspm_normal_t normal_sigs;
  assign normal_sigs.envelope = ENVELOPE_IN;
  assign normal_sigs.tx_nrz = TX_NRZ_IN;
  assign normal_sigs.manch_subc = MANCH_SUBC_IN;
  assign normal_sigs.manch = MANCH_IN;

  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] offset);
    return addr == offset;
  endfunction : hit

  function automatic logic analog_reserved(input logic [4:0] code);
    return code > `TSPM_ANALOG_LAST_CODE;
  endfunction : analog_reserved

  // Selection registers
  logic [4:0] analog_probe_code_r;
  logic [4:0] analog_probe_code_nxt;
  logic route_digital_probe_bit_r;
  logic route_digital_probe_bit_nxt;
  logic [6:0] digital_probe_code_r;
  logic [6:0] digital_probe_code_nxt;
  logic [2:0] multifunction_out_source_r;
  logic [2:0] multifunction_out_source_nxt;

  // Sticky flags for codes that software should not have written
  logic ana_rsv_flag_r;
  logic ana_rsv_flag_nxt;
  logic dig_undef_flag_r;
  logic dig_undef_flag_nxt;

  // Registered outputs
  logic pin_r;
  logic pin_nxt;
  logic probe_active_r;
  logic probe_active_nxt;
  logic [4:0] ana_out_r;
  logic [4:0] ana_out_nxt;
  logic ana_valid_r;
  logic ana_valid_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic normal_level;
  tspm_dprobe_t probe_kind;
  logic probe_level;

  // Pin source selection
  tspm_normal_src u_normal_src (
    .src_sel_in(multifunction_out_source_r),
    .sigs_in(normal_sigs),
    .level_out(normal_level)
  );

  tspm_dprobe_dec u_dprobe_dec (
    .route_in(route_digital_probe_bit_r),
    .code_in(digital_probe_code_r),
    .probes_in(probes),
    .normal_level_in(normal_level),
    .kind_out(probe_kind),
    .level_out(probe_level)
  );

  // Analog node select register
  always_comb begin
    analog_probe_code_nxt = analog_probe_code_r;
    if (bus.wr && hit(bus.addr, `TSPM_ADDR_ANALOG_SEL)) begin
      analog_probe_code_nxt = bus.wdata[4:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      analog_probe_code_r <= `TSPM_RST_ANALOG_SEL;
    end else begin
      analog_probe_code_r <= analog_probe_code_nxt;
    end
  end

  // Digital probe select register: route bit above the code
  always_comb begin
    route_digital_probe_bit_nxt = route_digital_probe_bit_r;
    digital_probe_code_nxt = digital_probe_code_r;
    if (bus.wr && hit(bus.addr, `TSPM_ADDR_DIGITAL_SEL)) begin
      route_digital_probe_bit_nxt = bus.wdata[`TSPM_ROUTE_BIT];
      digital_probe_code_nxt = bus.wdata[6:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      route_digital_probe_bit_r <= `TSPM_RST_ROUTE;
      digital_probe_code_r <= `TSPM_RST_DIGITAL_CODE;
    end else begin
      route_digital_probe_bit_r <= route_digital_probe_bit_nxt;
      digital_probe_code_r <= digital_probe_code_nxt;
    end
  end

  // Normal source select register
  always_comb begin
    multifunction_out_source_nxt = multifunction_out_source_r;
    if (bus.wr && hit(bus.addr, `TSPM_ADDR_MULTIFUNCTION_OUT_PIN_SRC)) begin
      multifunction_out_source_nxt = bus.wdata[2:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      multifunction_out_source_r <= `TSPM_RST_MULTIFUNCTION_OUT_PIN_SRC;
    end else begin
      multifunction_out_source_r <= multifunction_out_source_nxt;
    end
  end

  // Status write; ones clear the sticky misuse flags
  logic status_clr;
  assign status_clr = bus.wr && hit(bus.addr, `TSPM_ADDR_STATUS);

  // Reserved analog code flag; a new event beats a clear
  always_comb begin
    ana_rsv_flag_nxt = ana_rsv_flag_r;
    if (status_clr && bus.wdata[`TSPM_ST_ANA_RSV_BIT]) begin
      ana_rsv_flag_nxt = 1'b0;
    end
    if (analog_reserved(analog_probe_code_r)) begin
      ana_rsv_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ana_rsv_flag_r <= 1'b0;
    end else begin
      ana_rsv_flag_r <= ana_rsv_flag_nxt;
    end
  end

  // Undefined digital code flag; a new event beats a clear
  always_comb begin
    dig_undef_flag_nxt = dig_undef_flag_r;
    if (status_clr && bus.wdata[`TSPM_ST_DIG_UNDEF_BIT]) begin
      dig_undef_flag_nxt = 1'b0;
    end
    if (probe_kind == TSPM_DP_UNDEFINED) begin
      dig_undef_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dig_undef_flag_r <= 1'b0;
    end else begin
      dig_undef_flag_r <= dig_undef_flag_nxt;
    end
  end

  // Pin level, one cycle behind the selection
  always_comb begin
    pin_nxt = probe_level;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Probe active status, beside the pin level
  always_comb begin
    probe_active_nxt = probe_kind != TSPM_DP_NORMAL;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      probe_active_r <= 1'b0;
    end else begin
      probe_active_r <= probe_active_nxt;
    end
  end

  // Analog select outputs; reserved codes pass with valid low
  always_comb begin
    ana_out_nxt = analog_probe_code_r;
    ana_valid_nxt = !analog_reserved(analog_probe_code_r);
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ana_out_r <= `TSPM_RST_ANALOG_SEL;
      ana_valid_r <= 1'b1;
    end else begin
      ana_out_r <= ana_out_nxt;
      ana_valid_r <= ana_valid_nxt;
    end
  end

  // Status word as software sees it
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[`TSPM_ST_PIN_BIT] = pin_r;
    status_word[`TSPM_ST_PROBE_BIT] = probe_active_r;
    status_word[`TSPM_ST_ANA_RSV_BIT] = ana_rsv_flag_r;
    status_word[`TSPM_ST_DIG_UNDEF_BIT] = dig_undef_flag_r;
  end

  // Read data, valid only in the cycle after the read strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `TSPM_ADDR_ANALOG_SEL: rdata_nxt = {3'h0, analog_probe_code_r};
        `TSPM_ADDR_DIGITAL_SEL: begin
          rdata_nxt = {route_digital_probe_bit_r, digital_probe_code_r};
        end
        `TSPM_ADDR_MULTIFUNCTION_OUT_PIN_SRC: rdata_nxt = {5'h00, multifunction_out_source_r};
        `TSPM_ADDR_STATUS: rdata_nxt = status_word;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign MULTIFUNCTION_OUT_PIN_OUT = pin_r;
  assign ANALOG_PROBE_CODE_OUT = ana_out_r;
  assign ANALOG_PROBE_VALID_OUT = ana_valid_r;
  assign REG_RDATA_OUT = rdata_r;

endmodule : tspm_top
`default_nettype wire

/* tspm_lab_scope.sv */
// Lab scope model: counts rising edges seen on the multifunction pin.
// Assumes the pin is sampled on the block clock, like a logic analyser.
`timescale 1ns/10ps
`default_nettype none
module tspm_lab_scope
  import tspm_pkg::*;
(
  input wire logic clk_in,
  input wire logic pin_in,
  output logic [7:0] edges_out
);
  logic last_r = 1'b0;
  logic [7:0] cnt_r = 8'h00;
  assign edges_out = cnt_r;
  always @(posedge clk_in) begin
    if (pin_in && !last_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
    last_r <= pin_in;
  end
endmodule : tspm_lab_scope
`default_nettype wire

/* tspm_monitor.sv */
// Checker of the probe mux top ports, bound into tspm_top.
// Assumes one-cycle strobes and selection registers at 0x1 and 0x2.
`timescale 1ns/10ps
`default_nettype none
module tspm_monitor
  import tspm_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic RX_DATA_IN,
  input wire logic RX_VALID_IN,
  input wire logic RX_COLL_IN,
  input wire logic SERIAL_CLK_IN,
  input wire logic RD_SYNC_IN,
  input wire logic WR_SYNC_IN,
  input wire logic CORE_CLK_IN,
  input wire logic ENVELOPE_IN,
  input wire logic TX_NRZ_IN,
  input wire logic MANCH_SUBC_IN,
  input wire logic MANCH_IN,
  input wire logic MULTIFUNCTION_OUT_PIN_OUT,
  input wire logic [4:0] ANALOG_PROBE_CODE_OUT,
  input wire logic ANALOG_PROBE_VALID_OUT
);
  logic [7:0] sel_r;
  logic [2:0] src_r;
  logic [7:0] nv;
  logic pin;
  logic nrm;
  assign pin = MULTIFUNCTION_OUT_PIN_OUT;
  assign nv = {2'b00, MANCH_IN, MANCH_SUBC_IN, TX_NRZ_IN,
    ENVELOPE_IN, 2'b10};
  assign nrm = nv[src_r];
  // Shadow of the two pin selection registers
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sel_r <= 8'h00;
      src_r <= 3'h0;
    end else if (REG_WR_IN && REG_ADDR_IN == 4'h1) begin
      sel_r <= REG_WDATA_IN;
    end else if (REG_WR_IN && REG_ADDR_IN == 4'h2) begin
      src_r <= REG_WDATA_IN[2:0];
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_rxd; sel_r == 8'hF4 |=> pin == $past(RX_DATA_IN); endproperty
  a_rxd: assert property (p_rxd) else $error("rx data probe");
  property p_vld; sel_r == 8'hE4 |=> pin == $past(RX_VALID_IN); endproperty
  a_vld: assert property (p_vld) else $error("valid probe");
  property p_col; sel_r == 8'hD4 |=> pin == $past(RX_COLL_IN); endproperty
  a_col: assert property (p_col) else $error("coll probe");
  property p_sck; sel_r == 8'hC4 |=> pin == $past(SERIAL_CLK_IN); endproperty
  a_sck: assert property (p_sck) else $error("ser clk probe");
  property p_rds; sel_r == 8'hB5 |=> pin == $past(RD_SYNC_IN); endproperty
  a_rds: assert property (p_rds) else $error("rd probe");
  property p_wrs; sel_r == 8'hA5 |=> pin == $past(WR_SYNC_IN); endproperty
  a_wrs: assert property (p_wrs) else $error("wr probe");
  property p_cck; sel_r == 8'h96 |=> pin == $past(CORE_CLK_IN); endproperty
  a_cck: assert property (p_cck) else $error("core clk probe");
  property p_nrm;
    !sel_r[7] || sel_r[6:0] == 7'h00 |=> pin == $past(nrm);
  endproperty
  a_nrm: assert property (p_nrm) else $error("normal src");
  property p_acd;
    REG_WR_IN && REG_ADDR_IN == 4'h0 |-> ##2
      ANALOG_PROBE_CODE_OUT == $past(REG_WDATA_IN[4:0], 2);
  endproperty
  a_acd: assert property (p_acd) else $error("analog code");
  property p_avl;
    ANALOG_PROBE_VALID_OUT == (ANALOG_PROBE_CODE_OUT <= 5'h0C);
  endproperty
  a_avl: assert property (p_avl) else $error("analog valid");
endmodule : tspm_monitor
bind tspm_top tspm_monitor u_mon (
  .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN), .RX_DATA_IN(RX_DATA_IN),
  .RX_VALID_IN(RX_VALID_IN), .RX_COLL_IN(RX_COLL_IN),
  .SERIAL_CLK_IN(SERIAL_CLK_IN), .RD_SYNC_IN(RD_SYNC_IN),
  .WR_SYNC_IN(WR_SYNC_IN), .CORE_CLK_IN(CORE_CLK_IN),
  .ENVELOPE_IN(ENVELOPE_IN), .TX_NRZ_IN(TX_NRZ_IN),
  .MANCH_SUBC_IN(MANCH_SUBC_IN), .MANCH_IN(MANCH_IN),
  .MULTIFUNCTION_OUT_PIN_OUT(MULTIFUNCTION_OUT_PIN_OUT),
  .ANALOG_PROBE_CODE_OUT(ANALOG_PROBE_CODE_OUT),
  .ANALOG_PROBE_VALID_OUT(ANALOG_PROBE_VALID_OUT)
);
`default_nettype wire

/* tspm_top_tb.sv */
// Testbench of the probe mux: registers, analog code, pin routing.
// Assumes the lab scope model and the checker are compiled beside it.
`timescale 1ns/10ps
`default_nettype none
module tspm_top_tb
  import tspm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  tspm_probe_t prb = '0;
  tspm_normal_t nrm = '0;
  logic [7:0] rdata;
  logic pin;
  logic [4:0] acode;
  logic avalid;
  logic [7:0] edges;
  logic [7:0] v;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] dc [7] = '{8'hF4, 8'hE4, 8'hD4, 8'hC4, 8'hB5, 8'hA5, 8'h96};
  always #10 clk = ~clk;
  tspm_top DUT (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .RX_DATA_IN(prb.rx_data),
    .RX_VALID_IN(prb.rx_valid), .RX_COLL_IN(prb.rx_coll),
    .SERIAL_CLK_IN(prb.serial_clk), .RD_SYNC_IN(prb.rd_sync),
    .WR_SYNC_IN(prb.wr_sync), .CORE_CLK_IN(prb.core_clk),
    .ENVELOPE_IN(nrm.envelope), .TX_NRZ_IN(nrm.tx_nrz),
    .MANCH_SUBC_IN(nrm.manch_subc), .MANCH_IN(nrm.manch),
    .MULTIFUNCTION_OUT_PIN_OUT(pin), .ANALOG_PROBE_CODE_OUT(acode),
    .ANALOG_PROBE_VALID_OUT(avalid));
  tspm_lab_scope u_scope (.clk_in(clk), .pin_in(pin), .edges_out(edges));
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e,
      input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp("rdata", e, rdata & m);
    @(posedge clk);
    #1 cmp("rdata idle", 8'h00, rdata);
  endtask : rd_reg
  task automatic pin_is(input logic e);
    repeat (2) @(posedge clk);
    #1 cmp("pin", {7'h00, e}, {7'h00, pin});
  endtask : pin_is
  initial begin
    #60000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 cmp("avalid", 8'h01, {7'h00, avalid});
    cmp("pin", 8'h00, {7'h00, pin});
    rd_reg(4'h1, 8'h00, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      wr_reg(4'h0, 8'(i));
      rd_reg(4'h0, 8'(i), 8'h1F);
      cmp("acode", 8'(i), {3'h0, acode});
      cmp("avalid", {7'h00, i < 13}, {7'h00, avalid});
    end
    rd_reg(4'h3, 8'h04, 8'h04);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h3, 8'h04);
    rd_reg(4'h3, 8'h00, 8'h04);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      nrm <= k ? 4'b0101 : 4'b1010;
      for (int c = 0; c < 8; c++) begin
        wr_reg(4'h2, 8'(c));
        v = {2'b00, nrm.manch, nrm.manch_subc, nrm.tx_nrz, nrm.envelope,
          2'b10};
        pin_is(v[c]);
      end
    end
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h1, 8'hF4);
    #1 cmp("pin old", 8'h01, {7'h00, pin});
    @(posedge clk);
    #1 cmp("pin new", 8'h00, {7'h00, pin});
    for (int i = 0; i < 7; i++) begin
      wr_reg(4'h1, dc[i]);
      prb <= tspm_probe_t'(7'h40 >> i);
      pin_is(1'b1);
      @(posedge clk);
      prb <= tspm_probe_t'(~(7'h40 >> i));
      pin_is(1'b0);
      rd_reg(4'h1, dc[i], 8'hFF);
    end
    wr_reg(4'h1, 8'h00);
    pin_is(1'b1);
    wr_reg(4'h1, 8'h80);
    pin_is(1'b1);
    wr_reg(4'h1, 8'hFF);
    pin_is(1'b0);
    wr_reg(4'h3, 8'h08);
    rd_reg(4'h3, 8'h0A, 8'hFF);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h3, 8'h08);
    rd_reg(4'h3, 8'h01, 8'hFF);
    wr_reg(4'h1, 8'h96);
    prb <= '0;
    pin_is(1'b0);
    v = edges;
    repeat (20) begin
      @(posedge clk);
      prb.core_clk <= ~prb.core_clk;
    end
    repeat (3) @(posedge clk);
    #1 cmp("edges", v + 8'h0A, edges);
    finish_test();
  end
endmodule : tspm_top_tb
`default_nettype wire
